// file: logic/pld_array.sv
// top of the sixteen macrocell logic array: pins, AND array, connection store
// assumes pins and clock inputs are asynchronous to clk_i; register port is
// on clk_i and never waits
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sixteen_macrocell_pld_array (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [3:0] ded_in_i,
  input wire logic [15:0] io_in_i,
  output logic [15:0] io_out_o,
  output logic [15:0] io_oe_o,
  input wire logic left_half_sync_clock_i,
  input wire logic right_half_sync_clock_i,
  input wire logic [8:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // a line with its connection open reads as one; both copies of a
  // signal connected can never both be one, so the term goes false
  function automatic logic term_eval(input logic [39:0] conn, input logic [39:0] lines);
    return &(lines | ~conn);
  endfunction

  function automatic logic is_cfg(input logic [8:0] addr);
    return addr[8:4] == pld_pkg::CFG_BASE[8:4];
  endfunction

  // ****************************************************************
  // pin synchronisers and clock edges
  // ****************************************************************
  logic [21:0] pins_sync;
  logic [3:0] ded_s;
  logic [15:0] io_s;
  logic [1:0] sclk_s;
  logic [1:0] sclk_prev_reg;
  logic [1:0] sync_edge;

  sync_2ff #(
    .WIDTH(pld_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .d_i({right_half_sync_clock_i, left_half_sync_clock_i, io_in_i, ded_in_i}),
    .q_o(pins_sync)
  );

  assign ded_s = pins_sync[3:0];
  assign io_s = pins_sync[19:4];
  assign sclk_s = pins_sync[21:20];

  always_ff @(posedge clk_i) begin
    if (reset_i) sclk_prev_reg <= 2'h0;
    else if (ce_i) sclk_prev_reg <= sclk_s;
  end

  // falling edges are ignored
  assign sync_edge = sclk_s & ~sclk_prev_reg; // [RULE15]

  // ****************************************************************
  // array lines
  // ****************************************************************
  logic [15:0] cell_q;
  logic [15:0] cell_out;
  logic [15:0] cell_oe;
  logic [15:0] cell_fb;
  logic [19:0] sig;
  logic [39:0] lines_next;
  logic [39:0] lines_reg;

  assign sig = {cell_fb, ded_s};

  always_comb begin
    lines_next = '0;
    for (int k = 0; k < pld_pkg::NUM_SIG; k++) begin
      lines_next[2*k] = sig[k]; // [RULE5]
      lines_next[2*k+1] = ~sig[k]; // [RULE5]
    end
  end

  // the lines are registered so that feedback never forms a combinational
  // loop; every path through the array costs one clk_i cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) lines_reg <= '0;
    else if (ce_i) lines_reg <= lines_next;
  end

  // ****************************************************************
  // connection store
  // ****************************************************************
  logic [39:0] fuse_mem [pld_pkg::NUM_TERMS];
  logic fuse_hit;
  logic [7:0] fuse_idx;

  assign fuse_hit = addr_i <= pld_pkg::FUSE_LAST_ADDR;
  assign fuse_idx = addr_i[8:1];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int t = 0; t < pld_pkg::NUM_TERMS; t++) begin
        fuse_mem[t] <= pld_pkg::FUSE_ERASED; // [RULE9]
      end
    end else if (ce_i && we_i) begin
      if (addr_i == pld_pkg::ERASE_ADDR && wdata_i[0]) begin
        for (int t = 0; t < pld_pkg::NUM_TERMS; t++) begin
          fuse_mem[t] <= pld_pkg::FUSE_ERASED; // [RULE9]
        end
      end else if (fuse_hit && !addr_i[0]) begin
        // writing can only open connections, as an EPROM cell would
        fuse_mem[fuse_idx][31:0] <= fuse_mem[fuse_idx][31:0] & wdata_i; // [RULE9]
      end else if (fuse_hit) begin
        fuse_mem[fuse_idx][39:32] <= fuse_mem[fuse_idx][39:32] & wdata_i[7:0]; // [RULE9]
      end
    end
  end

  // ****************************************************************
  // product terms
  // ****************************************************************
  logic [159:0] pterm;

  genvar gt;
  generate
    for (gt = 0; gt < pld_pkg::NUM_TERMS; gt++) begin : g_term
      assign pterm[gt] = term_eval(fuse_mem[gt], lines_reg); // [RULE3] [RULE6] [RULE7] [RULE8]
    end
  endgenerate

  // ****************************************************************
  // macrocell configuration
  // ****************************************************************
  logic [8:0] cfg_reg [pld_pkg::NUM_CELLS];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int c = 0; c < pld_pkg::NUM_CELLS; c++) begin
        cfg_reg[c] <= pld_pkg::CFG_RESET;
      end
    end else if (ce_i && we_i && is_cfg(addr_i)) begin
      cfg_reg[addr_i[3:0]] <= wdata_i[pld_pkg::CFG_W-1:0]; // [RULE10] [RULE11]
    end
  end

  // ****************************************************************
  // macrocells
  // ****************************************************************
  genvar gc;
  generate
    for (gc = 0; gc < pld_pkg::NUM_CELLS; gc++) begin : g_cell
      pld_macrocell u_cell (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .pterm_i(pterm[gc*pld_pkg::TERMS_PER_CELL +: pld_pkg::TERMS_PER_CELL]), // [RULE4]
        .cfg_i(cfg_reg[gc]),
        .sync_edge_i(sync_edge[gc / pld_pkg::HALF_CELLS]), // [RULE13]
        .pin_i(io_s[gc]),
        .q_o(cell_q[gc]),
        .pin_out_o(cell_out[gc]),
        .pin_oe_o(cell_oe[gc]),
        .fb_o(cell_fb[gc])
      ); // [RULE2]
    end
  endgenerate

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      io_out_o <= 16'h0000;
      io_oe_o <= 16'h0000;
    end else if (ce_i) begin
      io_out_o <= cell_out; // [RULE1]
      io_oe_o <= cell_oe; // [RULE1]
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (fuse_hit && !addr_i[0]) begin
      rd_next = fuse_mem[fuse_idx][31:0];
    end else if (fuse_hit) begin
      rd_next = {24'h00_0000, fuse_mem[fuse_idx][39:32]};
    end else if (is_cfg(addr_i)) begin
      rd_next = {23'h00_0000, cfg_reg[addr_i[3:0]]};
    end else if (addr_i == pld_pkg::STAT_Q_ADDR) begin
      rd_next = {16'h0000, cell_q};
    end else if (addr_i == pld_pkg::STAT_OE_ADDR) begin
      rd_next = {16'h0000, io_oe_o};
    end else if (addr_i == pld_pkg::STAT_PIN_ADDR) begin
      rd_next = {10'h000, pins_sync};
    end else if (addr_i == pld_pkg::STAT_LINES_LO) begin
      rd_next = lines_reg[31:0];
    end else if (addr_i == pld_pkg::STAT_LINES_HI) begin
      rd_next = {24'h00_0000, lines_reg[39:32]};
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (reset_i) rdata_o <= 32'h0000_0000;
    else if (ce_i) rdata_o <= re_i ? rd_next : 32'h0000_0000;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [19:0] line_t;
  logic [19:0] line_c;

  // even lines carry the signals, odd lines their complements
  always_comb begin
    line_t = 20'h0_0000;
    line_c = 20'h0_0000;
    for (int k = 0; k < pld_pkg::NUM_SIG; k++) begin
      line_t[k] = lines_reg[2*k];
      line_c[k] = lines_reg[2*k+1];
    end
  end

  property p_fuse_and;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && we_i && addr_i == 9'h000) |=>
        fuse_mem[0][31:0] == ($past(fuse_mem[0][31:0]) & $past(wdata_i));
  endproperty
  a_fuse_and: assert property (p_fuse_and) else $error("fuse write set a connection"); // [RULE9]

  property p_erased_after_reset;
    @(posedge clk_i) disable iff (reset_i)
      $fell(reset_i) |-> (fuse_mem[5] == pld_pkg::FUSE_ERASED && cell_q == 16'h0000);
  endproperty
  a_erased_after_reset: assert property (p_erased_after_reset) else $error("not erased"); // [RULE9]

  property p_both_false;
    @(posedge clk_i) disable iff (reset_i) (fuse_mem[3][1:0] == 2'h3) |-> !pterm[3];
  endproperty
  a_both_false: assert property (p_both_false) else $error("term true with both copies"); // [RULE6]

  property p_open_true;
    @(posedge clk_i) disable iff (reset_i) (fuse_mem[7] == 40'h00_0000_0000) |-> pterm[7];
  endproperty
  a_open_true: assert property (p_open_true) else $error("open term not true"); // [RULE8]

  property p_read_slot;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && !re_i) ##1 ce_i |-> rdata_o == 32'h0000_0000;
  endproperty
  a_read_slot: assert property (p_read_slot) else $error("read data outside its slot"); // [RULE1]

  property p_lines_pair;
    @(posedge clk_i) disable iff (reset_i)
      ce_i |=> (line_t == $past(sig) && line_c == ~$past(sig));
  endproperty
  a_lines_pair: assert property (p_lines_pair) else $error("lines not paired"); // [RULE5]

  property p_fuse_hi_and;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && we_i && addr_i == 9'h001) |=>
        fuse_mem[0][39:32] == ($past(fuse_mem[0][39:32]) & $past(wdata_i[7:0]));
  endproperty
  a_fuse_hi_and: assert property (p_fuse_hi_and) else $error("high fuse write set a line"); // [RULE9]

  property p_erase_all;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && we_i && addr_i == pld_pkg::ERASE_ADDR && wdata_i[0]) |=>
        (fuse_mem[0] == pld_pkg::FUSE_ERASED && fuse_mem[159] == pld_pkg::FUSE_ERASED);
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("erase left a line open"); // [RULE9]

  property p_cfg_write;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && we_i && addr_i == pld_pkg::CFG_BASE) |=> cfg_reg[0] == $past(wdata_i[8:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cell setting not stored"); // [RULE11]

  property p_pin_regs;
    @(posedge clk_i) disable iff (reset_i)
      ce_i |=> (io_out_o == $past(cell_out) && io_oe_o == $past(cell_oe));
  endproperty
  a_pin_regs: assert property (p_pin_regs) else $error("pin drivers lag the cells"); // [RULE1]

  property p_read_data;
    @(posedge clk_i) disable iff (reset_i) (ce_i && re_i) |=> rdata_o == $past(rd_next);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not returned"); // [RULE1]

  property p_q_status;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && re_i && addr_i == pld_pkg::STAT_Q_ADDR) |=> rdata_o == {16'h0000, $past(cell_q)};
  endproperty
  a_q_status: assert property (p_q_status) else $error("register status wrong"); // [RULE10]

  property p_edge_pulse;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && sync_edge != 2'h0) |=> (sync_edge & $past(sync_edge)) == 2'h0;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("clock edge seen twice"); // [RULE15]
endmodule

// file: logic/pld_pkg.sv
// constants, field layouts and types of the sixteen macrocell logic array
// assumes a single 10 MHz clock and a plain address/strobe register port
// How it works
// [RULE1] four dedicated inputs, sixteen two-way pins, two synchronous clock inputs
// [RULE2] sixteen macrocells, one per two-way pin
// [RULE3] forty array lines feed 160 product terms, ten per macrocell
// [RULE4] per cell: eight sum terms, one clear term, one enable-or-clock term
// [RULE5] array lines are true and inverted copies of inputs and feedbacks
// [RULE6] a term with both copies of one signal connected is false
// [RULE7] a signal with both copies open does not affect the term
// [RULE8] a term with every connection open is true
// [RULE9] erased array has every connection made; programming only opens connections
// [RULE10] each register is D, T, SR or JK without losing terms
// [RULE11] per cell combinational or registered output and feedback, selectable polarity
// [RULE12] register may be clocked by a product term instead
// [RULE13] left clock serves cells 0 to 7, right clock cells 8 to 15
// [RULE14] any subset of registers may use their half's synchronous clock
// [RULE15] synchronous clocks load on rising edges only
// [RULE16] clear term true clears register regardless of clock; reset clears too
// [RULE17] three-state mode: enable term drives buffer, synchronous clock used
// [RULE18] always-enabled mode: buffer driven, enable/clock term clocks register
// [RULE19] invert bit inverts every register input, both JK and SR inputs
// [RULE20] D loads, T toggles, JK/SR set reset hold, JK toggles on both
package pld_pkg;
  localparam int NUM_DED = 4;
  localparam int NUM_CELLS = 16;
  localparam int NUM_SIG = 20;
  localparam int ARRAY_W = 40;
  localparam int TERMS_PER_CELL = 10;
  localparam int NUM_TERMS = 160;
  localparam int HALF_CELLS = 8;
  localparam int SPLIT_TERMS = 4;
  localparam int CLEAR_TERM = 8;
  localparam int OECLK_TERM = 9;
  localparam int SYNC_W = 22;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int FUSE_HI_W = 8;
  localparam int CFG_W = 9;

  localparam logic [8:0] FUSE_LAST_ADDR = 9'h13F;
  localparam logic [8:0] CFG_BASE = 9'h140;
  localparam logic [8:0] STAT_Q_ADDR = 9'h150;
  localparam logic [8:0] STAT_OE_ADDR = 9'h151;
  localparam logic [8:0] STAT_PIN_ADDR = 9'h152;
  localparam logic [8:0] STAT_LINES_LO = 9'h153;
  localparam logic [8:0] STAT_LINES_HI = 9'h154;
  localparam logic [8:0] ERASE_ADDR = 9'h15F;

  localparam int TYPE_LSB = 0;
  localparam int OUT_LSB = 2;
  localparam int FB_LSB = 4;
  localparam int INV_BIT = 6;
  localparam int POL_BIT = 7;
  localparam int MODE_BIT = 8;

  // erased cell: combinational, active low, pin feedback, three-state mode
  localparam logic [8:0] CFG_RESET = 9'h080;
  localparam logic [39:0] FUSE_ERASED = 40'hFF_FFFF_FFFF;

  typedef enum logic [1:0] {REG_D = 2'h0, REG_T = 2'h1, REG_JK = 2'h2, REG_SR = 2'h3} reg_type_t;
  typedef enum logic [1:0] {OUT_COMB = 2'h0, OUT_REG = 2'h1, OUT_NONE = 2'h2} out_sel_t;
  typedef enum logic [1:0] {FB_PIN = 2'h0, FB_REG = 2'h1, FB_NONE = 2'h2, FB_COMB = 2'h3} fb_sel_t;
endpackage

// file: logic/sync_2ff.sv
// two flip-flop synchroniser for pins that arrive from outside the clock domain
// assumes a synchronous active high reset and a clock enable that freezes it
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// file: logic/pld_macrocell.sv
// one macrocell: sum gates, configurable register, output and feedback muxes
// assumes product terms already evaluated on the same clock
`timescale 1ns/1ps
module pld_macrocell (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [9:0] pterm_i,
  input wire logic [8:0] cfg_i,
  input wire logic sync_edge_i,
  input wire logic pin_i,
  output logic q_o,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic fb_o
);
  pld_pkg::reg_type_t rtype;
  logic [1:0] out_sel;
  pld_pkg::fb_sel_t fb_sel;
  logic inv, pol, mode, clear;
  logic sum_all, a_in, b_in, d_in;
  logic q_reg, q_next, ptclk_prev_reg, pt_edge, clk_event;

  assign rtype = pld_pkg::reg_type_t'(cfg_i[pld_pkg::TYPE_LSB +: 2]);
  assign out_sel = cfg_i[pld_pkg::OUT_LSB +: 2];
  assign fb_sel = pld_pkg::fb_sel_t'(cfg_i[pld_pkg::FB_LSB +: 2]);
  assign inv = cfg_i[pld_pkg::INV_BIT];
  assign pol = cfg_i[pld_pkg::POL_BIT];
  assign mode = cfg_i[pld_pkg::MODE_BIT];
  assign clear = pterm_i[pld_pkg::CLEAR_TERM];

  // two-input types split the eight terms in halves, so no term is lost
  assign sum_all = |pterm_i[7:0]; // [RULE4] [RULE10]
  assign d_in = sum_all ^ inv; // [RULE19]
  assign a_in = (|pterm_i[pld_pkg::SPLIT_TERMS-1:0]) ^ inv; // [RULE19]
  assign b_in = (|pterm_i[7:pld_pkg::SPLIT_TERMS]) ^ inv; // [RULE19]

  assign pt_edge = pterm_i[pld_pkg::OECLK_TERM] & ~ptclk_prev_reg;
  assign clk_event = mode ? pt_edge : sync_edge_i; // [RULE12] [RULE14] [RULE17] [RULE18]

  always_comb begin
    q_next = q_reg;
    unique case (rtype)
      pld_pkg::REG_D: q_next = d_in; // [RULE20]
      pld_pkg::REG_T: q_next = q_reg ^ d_in; // [RULE20]
      pld_pkg::REG_JK: begin
        if (a_in && b_in) q_next = ~q_reg; // [RULE20]
        else if (a_in) q_next = 1'b1;
        else if (b_in) q_next = 1'b0;
      end
      pld_pkg::REG_SR: begin
        // both set and reset true holds, avoiding a race-dependent value
        if (a_in && !b_in) q_next = 1'b1; // [RULE20]
        else if (b_in && !a_in) q_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_reg <= 1'b0; // [RULE16]
    end else if (ce_i) begin
      if (clear) q_reg <= 1'b0; // [RULE16]
      else if (clk_event) q_reg <= q_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) ptclk_prev_reg <= 1'b0;
    else if (ce_i) ptclk_prev_reg <= pterm_i[pld_pkg::OECLK_TERM];
  end

  always_comb begin
    pin_out_o = ((out_sel == pld_pkg::OUT_REG) ? q_reg : sum_all) ^ pol; // [RULE11]
    pin_oe_o = (out_sel == pld_pkg::OUT_COMB || out_sel == pld_pkg::OUT_REG) &&
               (mode || pterm_i[pld_pkg::OECLK_TERM]); // [RULE17] [RULE18]
    unique case (fb_sel)
      pld_pkg::FB_PIN: fb_o = pin_i; // [RULE11]
      pld_pkg::FB_REG: fb_o = q_reg;
      pld_pkg::FB_NONE: fb_o = 1'b0;
      pld_pkg::FB_COMB: fb_o = sum_all;
    endcase
  end
  assign q_o = q_reg;

  property p_clear;
    @(posedge clk_i) disable iff (reset_i) (ce_i && clear) |=> !q_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("clear term did not clear"); // [RULE16]

  property p_d_load;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && !clear && clk_event && rtype == pld_pkg::REG_D) |=> q_reg == $past(d_in);
  endproperty
  a_d_load: assert property (p_d_load) else $error("d register did not load"); // [RULE20]

  property p_t_toggle;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && !clear && clk_event && rtype == pld_pkg::REG_T && d_in) |=> q_reg != $past(q_reg);
  endproperty
  a_t_toggle: assert property (p_t_toggle) else $error("t register did not toggle"); // [RULE20]

  property p_hold;
    @(posedge clk_i) disable iff (reset_i) (!clk_event && !clear) |=> $stable(q_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without clock"); // [RULE15]

  property p_three_state;
    @(posedge clk_i) disable iff (reset_i)
      (!mode && !pterm_i[pld_pkg::OECLK_TERM]) |-> !pin_oe_o;
  endproperty
  a_three_state: assert property (p_three_state) else $error("pin driven with enable false"); // [RULE17]

  property p_always_on;
    @(posedge clk_i) disable iff (reset_i)
      (mode && out_sel == pld_pkg::OUT_REG) |-> pin_oe_o;
  endproperty
  a_always_on: assert property (p_always_on) else $error("pin not driven in mode one"); // [RULE18]
endmodule

// file: test/board_model.sv
// board side of the logic array: dedicated input levels, pin levels, clock pins
// assumes the bench sets wanted levels and calls set_clk for clock edges
`timescale 1ns/1ps
module board_model (
  input wire logic clk_i,
  input wire logic [15:0] io_out_i,
  input wire logic [15:0] io_oe_i,
  input wire logic [3:0] ded_set_i,
  input wire logic [15:0] io_set_i,
  output logic [3:0] ded_in_o,
  output logic [15:0] io_in_o,
  output logic lclk_o,
  output logic rclk_o
);
  // ********************
  // pins
  // ********************
  initial begin
    ded_in_o = 4'h0;
    lclk_o = 1'b0;
    rclk_o = 1'b0;
  end
  always @(posedge clk_i) begin
    ded_in_o <= ded_set_i;
  end
  // a pin the device drives shows its value, otherwise the board level wins
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      io_in_o[b] = io_oe_i[b] ? io_out_i[b] : io_set_i[b];
    end
  end
  // levels are held for many cycles since the device only samples the clock pins
  task automatic set_clk(input logic right, input logic v);
    @(posedge clk_i);
    if (right) begin
      rclk_o <= v;
    end else begin
      lclk_o <= v;
    end
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// file: test/tb.sv
// self-checking bench of the sixteen macrocell logic array
// assumes the board model on the pins and a plain strobe register port
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] ded_set = 4'h0;
  logic [15:0] io_set = 16'h0000;
  logic [8:0] addr_i = 9'h000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [3:0] ded_in;
  logic [15:0] io_in;
  logic [15:0] io_out;
  logic [15:0] io_oe;
  logic lclk;
  logic rclk;
  logic [31:0] rdata;
  int miscompares = 0;
  int num_checks = 0;
  int seed = 75;
  logic [1:0] tp [2];
  logic iv [2];
  logic [15:0] qx = 16'h0000;

  always #50 clk_i = ~clk_i;

  sixteen_macrocell_pld_array dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .ded_in_i(ded_in), .io_in_i(io_in), .io_out_o(io_out), .io_oe_o(io_oe),
    .left_half_sync_clock_i(lclk), .right_half_sync_clock_i(rclk), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata));
  board_model board (.clk_i(clk_i), .io_out_i(io_out), .io_oe_i(io_oe), .ded_set_i(ded_set),
    .io_set_i(io_set), .ded_in_o(ded_in), .io_in_o(io_in), .lclk_o(lclk), .rclk_o(rclk));

  // ********************
  // tasks and expectations
  // ********************
  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic term_set(input int c, input int t, input logic [31:0] lo, input logic [7:0] hi);
    logic [8:0] a;
    a = 9'(2 * (10 * c + t));
    wr(a, lo);
    wr(a + 9'h001, {24'h0, hi});
  endtask
  task automatic erase;
    wr(pld_pkg::ERASE_ADDR, 32'h0000_0001);
  endtask
  // pins pass two sync stages, the line register and the output register
  task automatic settle;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [39:0] lines(input logic [19:0] s);
    logic [39:0] l;
    for (int k = 0; k < 20; k++) begin
      l[2*k] = s[k];
      l[2*k+1] = ~s[k];
    end
    return l;
  endfunction
  // true only if every connected line is high; both copies connected can never be
  function automatic logic term(input logic [39:0] f, input logic [19:0] s);
    return (f & lines(s)) == f;
  endfunction
  function automatic logic next_q(input logic [1:0] t, input logic v, input logic j,
    input logic k, input logic q);
    logic a;
    logic b;
    a = j ^ v;
    b = k ^ v;
    case (t)
      2'h0: return (j | k) ^ v;
      2'h1: return q ^ ((j | k) ^ v);
      2'h2: return (a & b) ? ~q : (a ? 1'b1 : (b ? 1'b0 : q));
      default: return (a & b) ? q : (a ? 1'b1 : (b ? 1'b0 : q));
    endcase
  endfunction

  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    logic [31:0] d;
    logic [7:0] f;
    logic [19:0] s;
    logic [39:0] l40;
    int c;
    int o;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk(9'h000, 32'hFFFF_FFFF);
    rdchk(9'h13F, 32'h0000_00FF);
    for (int i = 0; i < 16; i++) begin
      rdchk(pld_pkg::CFG_BASE + 9'(i), {23'h0, pld_pkg::CFG_RESET});
    end
    rdchk(pld_pkg::STAT_Q_ADDR, 32'h0);
    rdchk(9'h1A5, 32'h0);
    d = $random(seed);
    wr(9'h002, d);
    wr(9'h002, 32'hFFFF_FFFF);
    rdchk(9'h002, d);
    wr(pld_pkg::CFG_BASE, 32'h0000_0120);
    for (int i = 0; i < 12; i++) begin
      f = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : (i == 2) ? 8'h5A : 8'($random(seed));
      io_set <= 16'($random(seed));
      erase;
      wr(9'h000, {24'h0, f});
      wr(9'h001, 32'h0);
      ded_set <= (i == 2) ? 4'hC : 4'($random(seed));
      settle;
      s = {io_set[15:1], 1'b0, ded_set};
      l40 = lines(s);
      chk(32'(io_out[0]), 32'(term({32'h0, f}, s)));
      chk(32'(io_oe[0]), 32'h1);
      rdchk(pld_pkg::STAT_LINES_LO, l40[31:0]);
      rdchk(pld_pkg::STAT_LINES_HI, {24'h0, l40[39:32]});
    end
    wr(pld_pkg::CFG_BASE, 32'h0000_0024);
    wr(pld_pkg::CFG_BASE + 9'h008, 32'h0000_0024);
    tp[0] = 2'h0;
    tp[1] = 2'h0;
    iv[0] = 1'b0;
    iv[1] = 1'b0;
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      c = d[0] ? 8 : 0;
      o = 8 - c;
      tp[c/8] = d[6:5];
      iv[c/8] = d[7];
      erase;
      wr(pld_pkg::CFG_BASE + 9'(c), {23'h0, 1'b0, d[4], d[7], 2'h2, 2'h1, d[6:5]});
      if (d[1])
        term_set(c, 0, 32'h0, 8'h00);
      if (d[2])
        term_set(c, 4, 32'h0, 8'h00);
      if (d[3])
        term_set(c, 9, 32'h0, 8'h00);
      // the other half clock must leave this cell alone but loads its own cells
      board.set_clk(c == 0, 1'b1);
      board.set_clk(c == 0, 1'b0);
      qx[o] = next_q(tp[o/8], iv[o/8], 1'b0, 1'b0, qx[o]);
      board.set_clk(c != 0, 1'b1);
      qx[c] = next_q(tp[c/8], iv[c/8], d[1], d[2], qx[c]);
      rdchk(pld_pkg::STAT_Q_ADDR, {16'h0, qx});
      board.set_clk(c != 0, 1'b0);
      rdchk(pld_pkg::STAT_Q_ADDR, {16'h0, qx});
      chk(32'(io_oe[c]), 32'(d[3]));
      chk(32'(io_out[c]), 32'(qx[c] ^ d[4]));
      if (d[9]) begin
        term_set(c, 8, 32'h0, 8'h00);
        settle;
        qx[c] = 1'b0;
        rdchk(pld_pkg::STAT_Q_ADDR, {16'h0, qx});
      end
    end
    erase;
    wr(pld_pkg::CFG_BASE, 32'h0000_0125);
    term_set(0, 0, 32'h0, 8'h00);
    ded_set <= 4'h0;
    settle;
    term_set(0, 9, 32'h0000_0001, 8'h00);
    settle;
    chk(32'(io_oe[0]), 32'h1);
    ded_set <= 4'h1;
    settle;
    qx[0] = ~qx[0];
    rdchk(pld_pkg::STAT_Q_ADDR, {16'h0, qx});
    ded_set <= 4'h0;
    settle;
    board.set_clk(1'b0, 1'b1);
    board.set_clk(1'b0, 1'b0);
    rdchk(pld_pkg::STAT_Q_ADDR, {16'h0, qx});
    tally_and_finish;
  end
endmodule
